// ---- logic/shared_buffer_params.svh ----
`ifndef SHARED_BUFFER_PARAMS_SVH
`define SHARED_BUFFER_PARAMS_SVH

// =============================================
// buffer geometry
`define SB_WORDS 256
`define SB_WORD_BITS 32
`define SB_BANK_BITS 16
`define SB_BANKS 2
`define SB_WADDR_BITS 8
`define SB_ADR_BITS 32
`define SB_WADDR_LSB 1
`define SB_WADDR_MSB 8

// =============================================
// reset values and timing
`define SB_RDATA_RST 16'h0000
`define SB_STD_LATENCY 2
`define SB_FAST_LATENCY 1

`endif

// ---- logic/shared_buffer_pkg.sv ----
`include "shared_buffer_params.svh"

package shared_buffer_pkg;

  // =============================================
  // data and address types
  typedef logic [`SB_WORD_BITS-1:0] word_t;
  typedef logic [`SB_BANK_BITS-1:0] half_t;
  typedef logic [`SB_BANKS-1:0] sel_t;
  typedef logic [`SB_ADR_BITS-1:0] adr_t;
  typedef logic [`SB_WADDR_BITS-1:0] waddr_t;

  // =============================================
  // arbiter states
  typedef enum logic [1:0] {
    ARB_IDLE  = 2'b00,
    ARB_A_OWN = 2'b01,
    ARB_B_OWN = 2'b10
  } arb_state_t;

endpackage

// ---- logic/shared_buffer_bank.sv ----
`timescale 1ns/1ns
`include "shared_buffer_params.svh"

// one 256 x 16 bank with two synchronous ports on one clock
module shared_buffer_bank (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // port a
  input wire logic a_en_i,
  input wire logic a_we_i,
  input wire shared_buffer_pkg::waddr_t a_addr_i,
  input wire shared_buffer_pkg::half_t a_din_i,
  output shared_buffer_pkg::half_t a_dout_o,
  // port b
  input wire logic b_en_i,
  input wire logic b_we_i,
  input wire shared_buffer_pkg::waddr_t b_addr_i,
  input wire shared_buffer_pkg::half_t b_din_i,
  output shared_buffer_pkg::half_t b_dout_o
);
  import shared_buffer_pkg::*;

  half_t mem [`SB_WORDS];

  // =============================================
  // storage writes, arbiter keeps ports apart
  always_ff @(posedge sys_clk_i) begin
    if (a_en_i && a_we_i) begin
      mem[a_addr_i] <= a_din_i;
    end
    if (b_en_i && b_we_i) begin
      mem[b_addr_i] <= b_din_i;
    end
  end

  // =============================================
  // registered read ports
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      a_dout_o <= `SB_RDATA_RST;
    end else if (a_en_i) begin
      a_dout_o <= mem[a_addr_i];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      b_dout_o <= `SB_RDATA_RST;
    end else if (b_en_i) begin
      b_dout_o <= mem[b_addr_i];
    end
  end

endmodule

// ---- logic/shared_buffer_block.sv ----
// How it works
// [R01] 256x32 buffer behind two slave ports
// [R02] two 256x16 banks, low and high half
// [R03] select bit n enables bank n
// [R04] word address from address bits 8..1
// [R05] bank enable needs grant, strobe, select
// [R06] acknowledge is grant and strobe
// [R07] both ports read and write everything
// [R08] loser held off by withheld acknowledge
// [R09] two-bit arbiter state machine drives grants
// [R10] only acknowledge terminates, no retry or error
// [R11] single and block cycles accepted
// [R12] one shared clock, no output resets
// [R13] standard answers in two, fast in one
// [R14] simultaneous idle requests: port a first
// [R15] grant released when owner drops cycle
`timescale 1ns/1ns
`include "shared_buffer_params.svh"

module shared_buffer_block #(
  parameter bit FAST_VARIANT = 1'b0
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // port a slave
  input wire logic port_a_cyc_i,
  input wire logic port_a_strobe_i,
  input wire logic port_a_write_enable_i,
  input wire shared_buffer_pkg::sel_t port_a_select_i,
  input wire shared_buffer_pkg::adr_t port_a_adr_i,
  input wire shared_buffer_pkg::word_t port_a_dat_i,
  output shared_buffer_pkg::word_t port_a_dat_o,
  output logic port_a_ack_o,
  // port b slave
  input wire logic port_b_cyc_i,
  input wire logic port_b_strobe_i,
  input wire logic port_b_write_enable_i,
  input wire shared_buffer_pkg::sel_t port_b_select_i,
  input wire shared_buffer_pkg::adr_t port_b_adr_i,
  input wire shared_buffer_pkg::word_t port_b_dat_i,
  output shared_buffer_pkg::word_t port_b_dat_o,
  output logic port_b_ack_o
);
  import shared_buffer_pkg::*;

  arb_state_t state;
  arb_state_t next_state;
  logic port_a_own;
  logic port_b_own;
  logic port_a_fresh;
  logic port_b_fresh;
  logic port_a_grant;
  logic port_b_grant;
  logic port_a_capture;
  logic port_b_capture;
  waddr_t port_a_waddr;
  waddr_t port_b_waddr;
  sel_t port_a_bank_en;
  sel_t port_b_bank_en;
  sel_t port_a_rd_en;
  sel_t port_b_rd_en;
  sel_t port_a_wr_en;
  sel_t port_b_wr_en;
  logic bank_out_rst;

  // =============================================
  // arbiter
  // arbitrate on cycle, not strobe, so a block cycle keeps the buffer
  always_comb begin
    next_state = state;
    case (state)
      ARB_IDLE: begin
        if (port_a_cyc_i) begin
          next_state = ARB_A_OWN; // see [R14]
        end else if (port_b_cyc_i) begin
          next_state = ARB_B_OWN;
        end
      end
      ARB_A_OWN: begin
        if (!port_a_cyc_i) begin
          next_state = port_b_cyc_i ? ARB_B_OWN : ARB_IDLE; // see [R15]
        end
      end
      ARB_B_OWN: begin
        if (!port_b_cyc_i) begin
          next_state = port_a_cyc_i ? ARB_A_OWN : ARB_IDLE; // see [R15]
        end
      end
      default: begin
        next_state = ARB_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ARB_IDLE;
    end else begin
      state <= next_state; // see [R09]
    end
  end

  // owner decode from the arbiter state
  always_comb begin
    port_a_own = 1'b0;
    port_b_own = 1'b0;
    case (state)
      ARB_A_OWN: begin
        port_a_own = 1'b1;
      end
      ARB_B_OWN: begin
        port_b_own = 1'b1;
      end
      default: begin
        port_a_own = 1'b0;
        port_b_own = 1'b0;
      end
    endcase
  end

  // =============================================
  // read data freshness per beat
  // standard build samples only while owning, fast build samples ahead
  assign port_a_capture = port_a_strobe_i && (FAST_VARIANT || port_a_own); // see [R13]
  assign port_b_capture = port_b_strobe_i && (FAST_VARIANT || port_b_own); // see [R13]

  // fresh drops after each acknowledge, giving the gap between beats
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_a_fresh <= 1'b0;
    end else begin
      port_a_fresh <= port_a_capture && !port_a_ack_o; // see [R11]
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_b_fresh <= 1'b0;
    end else begin
      port_b_fresh <= port_b_capture && !port_b_ack_o; // see [R11]
    end
  end

  // ready toward each master, only for the owner
  assign port_a_grant = port_a_own && port_a_fresh; // see [R08]
  assign port_b_grant = port_b_own && port_b_fresh; // see [R08]

  // =============================================
  // acknowledge, the only terminating signal
  assign port_a_ack_o = port_a_grant && port_a_strobe_i; // see [R06] [R10]
  assign port_b_ack_o = port_b_grant && port_b_strobe_i; // see [R06] [R10]

  // =============================================
  // bank enables and word addresses
  assign port_a_waddr = port_a_adr_i[`SB_WADDR_MSB:`SB_WADDR_LSB]; // see [R04]
  assign port_b_waddr = port_b_adr_i[`SB_WADDR_MSB:`SB_WADDR_LSB]; // see [R04]

  // writes land once, on the acknowledge
  always_comb begin
    port_a_bank_en = '0;
    port_b_bank_en = '0;
    if (port_a_ack_o) begin
      port_a_bank_en = port_a_select_i; // see [R05]
    end
    if (port_b_ack_o) begin
      port_b_bank_en = port_b_select_i; // see [R05]
    end
  end

  // reads refresh every beat, so data at the acknowledge is current
  always_comb begin
    port_a_rd_en = '0;
    port_b_rd_en = '0;
    if (port_a_capture) begin
      port_a_rd_en = port_a_select_i; // see [R03]
    end
    if (port_b_capture) begin
      port_b_rd_en = port_b_select_i; // see [R03]
    end
  end

  // write enable only qualifies an enabled bank
  always_comb begin
    port_a_wr_en = '0;
    port_b_wr_en = '0;
    if (port_a_write_enable_i) begin
      port_a_wr_en = port_a_bank_en; // see [R05]
    end
    if (port_b_write_enable_i) begin
      port_b_wr_en = port_b_bank_en; // see [R05]
    end
  end

  // =============================================
  // bank output resets stay inactive
  assign bank_out_rst = 1'b0; // see [R12]

  // =============================================
  // storage banks, bank n carries bits 16n+15..16n
  for (genvar n = 0; n < `SB_BANKS; n++) begin : g_bank
    logic a_en;
    logic b_en;

    // enable covers prefetch reads and acknowledged writes
    assign a_en = port_a_rd_en[n] | port_a_wr_en[n];
    assign b_en = port_b_rd_en[n] | port_b_wr_en[n];

    shared_buffer_bank u_bank ( // see [R01] [R02] [R07] [R12]
      .sys_clk_i(sys_clk_i),
      .rst_i(bank_out_rst),
      .a_en_i(a_en),
      .a_we_i(port_a_wr_en[n]),
      .a_addr_i(port_a_waddr),
      .a_din_i(port_a_dat_i[n*`SB_BANK_BITS +: `SB_BANK_BITS]),
      .a_dout_o(port_a_dat_o[n*`SB_BANK_BITS +: `SB_BANK_BITS]),
      .b_en_i(b_en),
      .b_we_i(port_b_wr_en[n]),
      .b_addr_i(port_b_waddr),
      .b_din_i(port_b_dat_i[n*`SB_BANK_BITS +: `SB_BANK_BITS]),
      .b_dout_o(port_b_dat_o[n*`SB_BANK_BITS +: `SB_BANK_BITS])
    );
  end

endmodule

// ---- tb/shared_buffer_block_chk.sv ----
`timescale 1ns/1ns
// ==========
// port checks
module shared_buffer_block_chk (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic port_a_cyc_i,
  input wire logic port_a_strobe_i,
  input wire logic port_a_ack_o,
  input wire logic port_b_cyc_i,
  input wire logic port_b_strobe_i,
  input wire logic port_b_ack_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_tie;
    $rose(port_a_cyc_i) && $rose(port_b_cyc_i) && port_a_strobe_i && port_b_strobe_i;
  endsequence
  sequence s_lone_b;
    $rose(port_b_cyc_i) && port_b_strobe_i && !port_a_cyc_i && !$past(port_a_cyc_i);
  endsequence
  a_ack_excl: assert property (!(port_a_ack_o && port_b_ack_o))
    else $error("dual ack");
  a_a_gated: assert property (port_a_ack_o |-> port_a_strobe_i)
    else $error("a ack no strobe");
  a_b_gated: assert property (port_b_ack_o |-> port_b_strobe_i)
    else $error("b ack no strobe");
  a_a_pulse: assert property (port_a_ack_o |=> !port_a_ack_o)
    else $error("a ack long");
  a_b_pulse: assert property (port_b_ack_o |=> !port_b_ack_o)
    else $error("b ack long");
  a_tie_first: assert property (s_tie |-> !port_b_ack_o throughout (1'b1 ##[1:2] port_a_ack_o))
    else $error("tie lost by a");
  a_lone_lat: assert property (s_lone_b |-> ##[1:2] port_b_ack_o)
    else $error("b ack late");
  a_release: assert property ($fell(port_a_cyc_i) && port_b_strobe_i |-> ##[1:3] port_b_ack_o)
    else $error("b not served");
endmodule

// ---- tb/wb_master_model.sv ----
`timescale 1ns/1ns
// ==========
// master for one port
module wb_master_model (
  input wire logic sys_clk_i,
  input wire logic ack_i,
  input wire shared_buffer_pkg::word_t dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output shared_buffer_pkg::sel_t sel_o,
  output shared_buffer_pkg::adr_t adr_o,
  output shared_buffer_pkg::word_t dat_o
);
  import shared_buffer_pkg::*;
  int lat;
  int stalls = 0;
  initial {cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} = '0;
  // one beat from a falling edge, cycle left open
  task automatic beat(input logic w, sel_t s, adr_t a, word_t d, output word_t r);
    {we_o, sel_o, adr_o, dat_o, cyc_o, stb_o} = {w, s, a, d, 2'b11};
    lat = 0;
    do begin
      @(negedge sys_clk_i);
      lat++;
    end while (ack_i !== 1'b1 && lat < 20);
    if (ack_i !== 1'b1) stalls++;
    r = dat_i;
    @(negedge sys_clk_i);
  endtask
  // strobe down, cycle kept
  task automatic hold();
    stb_o = 1'b0;
  endtask
  // released lines flip
  task automatic close();
    {cyc_o, stb_o} = 2'b00;
    {we_o, sel_o, adr_o, dat_o} = ~{we_o, sel_o, adr_o, dat_o};
  endtask
endmodule

// ---- tb/shared_buffer_block_tb.sv ----
`timescale 1ns/1ns
`include "shared_buffer_params.svh"
// ==========
// bench top
module shared_buffer_block_tb;
  import shared_buffer_pkg::*;
  logic sys_clk_i = 0;
  logic rst_i = 1;
  logic ca, sa, wa, aa, cb, sb, wb, ab;
  sel_t la, lb;
  adr_t xa, xb;
  word_t ia, ib, oa, ob, r, q;
  logic fca, fsa, fwa, faa, fcb, fsb, fwb, fab;
  sel_t fla, flb;
  adr_t fxa, fxb;
  word_t fia, fib, foa, fob;
  time ta, tb, tc;
  int miscompares = 0;
  int n_tests = 0;
  int ticks = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  shared_buffer_block #(.FAST_VARIANT(1'b0)) dut_u (.sys_clk_i, .rst_i,
    .port_a_cyc_i(ca), .port_a_strobe_i(sa), .port_a_write_enable_i(wa),
    .port_a_select_i(la), .port_a_adr_i(xa), .port_a_dat_i(ia), .port_a_dat_o(oa),
    .port_a_ack_o(aa), .port_b_cyc_i(cb), .port_b_strobe_i(sb),
    .port_b_write_enable_i(wb), .port_b_select_i(lb), .port_b_adr_i(xb),
    .port_b_dat_i(ib), .port_b_dat_o(ob), .port_b_ack_o(ab));
  wb_master_model m_a (.sys_clk_i, .ack_i(aa), .dat_i(oa), .cyc_o(ca), .stb_o(sa),
    .we_o(wa), .sel_o(la), .adr_o(xa), .dat_o(ia));
  wb_master_model m_b (.sys_clk_i, .ack_i(ab), .dat_i(ob), .cyc_o(cb), .stb_o(sb),
    .we_o(wb), .sel_o(lb), .adr_o(xb), .dat_o(ib));
  shared_buffer_block #(.FAST_VARIANT(1'b1)) dut_fast_u (.sys_clk_i, .rst_i,
    .port_a_cyc_i(fca), .port_a_strobe_i(fsa), .port_a_write_enable_i(fwa),
    .port_a_select_i(fla), .port_a_adr_i(fxa), .port_a_dat_i(fia), .port_a_dat_o(foa),
    .port_a_ack_o(faa), .port_b_cyc_i(fcb), .port_b_strobe_i(fsb),
    .port_b_write_enable_i(fwb), .port_b_select_i(flb), .port_b_adr_i(fxb),
    .port_b_dat_i(fib), .port_b_dat_o(fob), .port_b_ack_o(fab));
  wb_master_model m_fa (.sys_clk_i, .ack_i(faa), .dat_i(foa), .cyc_o(fca), .stb_o(fsa),
    .we_o(fwa), .sel_o(fla), .adr_o(fxa), .dat_o(fia));
  wb_master_model m_fb (.sys_clk_i, .ack_i(fab), .dat_i(fob), .cyc_o(fcb), .stb_o(fsb),
    .we_o(fwb), .sel_o(flb), .adr_o(fxb), .dat_o(fib));
  task automatic chk(string n, word_t s, word_t e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    ticks++;
    if (ticks == 2000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // half words from both ports, b with stray address bits
  task automatic t_half();
    m_a.beat(1, 2'h1, 32'h10, 32'h1111_2222, r);
    m_a.close();
    m_b.beat(1, 2'h2, 32'h211, 32'h3333_4444, r);
    m_b.close();
    m_a.beat(0, 2'h3, 32'h10, '0, r);
    m_a.close();
    chk("merged word", r, 32'h3333_2222);
    chk("latency", m_a.lat, `SB_STD_LATENCY);
  endtask
  // block write from b
  task automatic t_block();
    @(negedge sys_clk_i);
    for (int i = 0; i < 2; i++) m_b.beat(1, 2'h3, 32'h40 + 2 * i, 32'hC0DE_0000 + i, r);
    m_b.close();
  endtask
  // both ports start together, a holds its cycle
  task automatic t_tie();
    @(negedge sys_clk_i);
    fork
      begin
        m_a.beat(0, 2'h3, 32'h40, '0, r);
        ta = $time;
        m_a.hold();
        repeat (2) @(negedge sys_clk_i);
        tc = $time;
        m_a.close();
      end
      begin
        m_b.beat(0, 2'h3, 32'h42, '0, q);
        tb = $time;
      end
    join
    m_b.close();
    chk("a read", r, 32'hC0DE_0000);
    chk("b read", q, 32'hC0DE_0001);
    chk("a first", 32'(ta < tb), 32'h1);
    chk("b after release", 32'(tb > tc), 32'h1);
  endtask
  // fast build: a writes, b reads it back
  task automatic t_fast();
    m_fa.beat(1, 2'h3, 32'h80, 32'h5A5A_A5A5, r);
    m_fa.close();
    m_fb.beat(0, 2'h3, 32'h80, '0, q);
    m_fb.close();
    chk("fast read", q, 32'h5A5A_A5A5);
    chk("fast a latency", m_fa.lat, `SB_FAST_LATENCY);
    chk("fast b latency", m_fb.lat, `SB_FAST_LATENCY);
  endtask
  initial begin
    repeat (12) @(negedge sys_clk_i);
    rst_i = 0;
    t_half();
    t_block();
    t_tie();
    t_fast();
    chk("stalls", m_a.stalls + m_b.stalls + m_fa.stalls + m_fb.stalls, 0);
    report_and_stop();
  end
endmodule
bind shared_buffer_block shared_buffer_block_chk chk_u (.sys_clk_i, .rst_i, .port_a_cyc_i,
  .port_a_strobe_i, .port_a_ack_o, .port_b_cyc_i, .port_b_strobe_i, .port_b_ack_o);
